// *** core/pin_map_params.svh ***
`ifndef PIN_MAP_PARAMS_SVH
`define PIN_MAP_PARAMS_SVH

// Byte addresses on the register bus
`define MAP_KEY_OFFSET      12'h000
`define MAP_CTRL_OFFSET     12'h004
`define MAP_PIN_BASE        12'h020

// Access key values
`define MAP_KEY_READ_VALUE  16'h96a5
`define MAP_KEY_GRANT_VALUE 16'h2d52

// Control register fields, control register reset values and pin selector reset value
`define MAP_CTRL_LOCK_BIT   0
`define MAP_CTRL_RECFG_BIT  1
`define MAP_LOCK_RESET      1'b1
`define MAP_RECFG_RESET     1'b0
`define MAP_SEL_RESET       8'h00

`endif

// *** core/pin_map_pkg.sv ***
package pin_map_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_FETCH,
    PH_ANSWER
  } apb_phase_t;

endpackage

// *** core/map_select_mem.sv ***
`timescale 1ns/1ps
`include "pin_map_params.svh"

module map_select_mem #(
  parameter int PINS     = 8,
  parameter int SEL_BITS = 8,
  parameter int IDX_W    = 3
) (
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  input  wire logic                     we,
  input  wire logic [IDX_W-1:0]         waddr,
  input  wire logic [SEL_BITS-1:0]      wdata,
  input  wire logic [IDX_W-1:0]         raddr,
  output logic      [SEL_BITS-1:0]      rdata,
  output logic      [PINS*SEL_BITS-1:0] contents
);

  localparam logic [SEL_BITS-1:0] SEL_RESET = SEL_BITS'(`MAP_SEL_RESET);

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_entry
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          contents[g*SEL_BITS +: SEL_BITS] <= SEL_RESET;
        end else if (we && waddr == IDX_W'(g)) begin
          contents[g*SEL_BITS +: SEL_BITS] <= wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= SEL_RESET;
    end else begin
      rdata <= contents[raddr*SEL_BITS +: SEL_BITS];
    end
  end

endmodule

// *** core/pin_function_map_regs.sv ***
// Notes on behaviour
// R1: Control register bits 31 to 2 read zero and ignore writes.
// R2: Bit 1 is writable reconfiguration permit, reset zero; one allows later sessions.
// R3: Bit 0 is read-only lock flag, reset one, untouched by writes.
// R4: Lock flag reads zero while map writes are granted, one while locked.
// R5: Each pin register holds an 8-bit function selector, reset zero.
// R6: Selector bits beyond the implemented width read zero and are read-only.
// R7: Key register reads a fixed value; writing the grant key opens access.
// R8: While locked, writes to pin registers and permit bit are discarded.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pin_map_params.svh"

module pin_function_map_regs #(
  parameter int PINS     = 8,
  parameter int SEL_BITS = 8
) (
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic      [PINS*SEL_BITS-1:0] pin_function_select,
  output logic                          map_write_locked,
  output logic                          remap_repeat_allow
);

  localparam int IDX_W = (PINS > 1) ? $clog2(PINS) : 1;
  localparam logic [11:0] PIN_END = 12'(`MAP_PIN_BASE + 4 * PINS);

  pin_map_pkg::apb_phase_t phase;
  logic                    session_used;
  logic [SEL_BITS-1:0]     mem_rdata;

  // Address decode
  wire        req        = psel && penable;
  wire        aligned    = paddr[1:0] == 2'b00;
  wire        hit_key    = aligned && paddr == `MAP_KEY_OFFSET;
  wire        hit_ctrl   = aligned && paddr == `MAP_CTRL_OFFSET;
  wire        hit_pin    = aligned && paddr >= `MAP_PIN_BASE && paddr < PIN_END;
  wire [11:0] pin_off    = paddr - `MAP_PIN_BASE;
  wire [IDX_W-1:0] pin_idx = pin_off[IDX_W+1:2];
  wire        mapped     = hit_key || hit_ctrl || hit_pin;
  wire        done       = phase == pin_map_pkg::PH_ANSWER && req;
  wire        wr_done    = done && pwrite && mapped;

  // Key handling and session control
  wire key_wr     = wr_done && hit_key;
  wire key_good   = pwdata[15:0] == `MAP_KEY_GRANT_VALUE;
  wire may_open   = !session_used || remap_repeat_allow;
  wire map_wr     = wr_done && hit_pin && !map_write_locked; // R8
  wire ctrl_wr    = wr_done && hit_ctrl && !map_write_locked; // R8

  // Read data selection
  wire [31:0] key_word  = {16'h0000, `MAP_KEY_READ_VALUE}; // R7
  wire [31:0] ctrl_word = {30'h0, remap_repeat_allow, map_write_locked}; // R1 R4
  wire [31:0] pin_word  = {{(32-SEL_BITS){1'b0}}, mem_rdata}; // R6
  wire [31:0] rd_word   = hit_key  ? key_word  :
                          hit_ctrl ? ctrl_word :
                          hit_pin  ? pin_word  : 32'h0000_0000;

  map_select_mem #(
    .PINS     (PINS),
    .SEL_BITS (SEL_BITS),
    .IDX_W    (IDX_W)
  ) u_mem (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .we       (map_wr), // R5
    .waddr    (pin_idx),
    .wdata    (pwdata[SEL_BITS-1:0]), // R6
    .raddr    (pin_idx),
    .rdata    (mem_rdata),
    .contents (pin_function_select)
  );

  // Bus phase sequencer: one fetch cycle then the answer cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase   <= pin_map_pkg::PH_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      case (phase)
        pin_map_pkg::PH_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (req) begin
            phase <= pin_map_pkg::PH_FETCH;
          end
        end
        pin_map_pkg::PH_FETCH: begin
          pready  <= 1'b1;
          pslverr <= !mapped;
          prdata  <= pwrite ? 32'h0000_0000 : rd_word;
          phase   <= pin_map_pkg::PH_ANSWER;
        end
        pin_map_pkg::PH_ANSWER: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          phase   <= pin_map_pkg::PH_IDLE;
        end
        default: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          phase   <= pin_map_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Control register state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      map_write_locked   <= `MAP_LOCK_RESET; // R3
      remap_repeat_allow <= `MAP_RECFG_RESET; // R2
      session_used       <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        remap_repeat_allow <= pwdata[`MAP_CTRL_RECFG_BIT]; // R2
      end
      if (key_wr) begin
        if (!key_good) begin
          map_write_locked <= 1'b1; // R4
        end else if (map_write_locked && may_open) begin
          map_write_locked <= 1'b0; // R7
          session_used     <= 1'b1;
        end
      end
    end
  end

  // Checks
  ctrl_reserved_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
    pready && req && !pwrite && hit_ctrl |-> prdata[31:2] == 30'h0)
    else $error("control reserved bits read nonzero");

  permit_write_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
    ctrl_wr |=> remap_repeat_allow == $past(pwdata[1]))
    else $error("permit bit did not take written value");

  lock_readonly_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R3
    wr_done && hit_ctrl |=> $stable(map_write_locked))
    else $error("control write changed lock flag");

  lock_readback_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R4
    phase == pin_map_pkg::PH_FETCH && !pwrite && hit_ctrl
      |=> prdata[0] == $past(map_write_locked) && pready)
    else $error("lock flag read back wrong");

  map_write_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
    map_wr |=> pin_function_select[$past(pin_idx)*SEL_BITS +: SEL_BITS]
      == $past(pwdata[SEL_BITS-1:0]))
    else $error("pin selector not updated");

  sel_upper_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R6
    pready && req && !pwrite && hit_pin |-> prdata[31:SEL_BITS] == '0)
    else $error("unused selector bits read nonzero");

  key_readback_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R7
    pready && req && !pwrite && hit_key |-> prdata == 32'h0000_96a5)
    else $error("key register read wrong value");

  key_grant_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R7
    key_wr && key_good && map_write_locked && may_open |=> !map_write_locked)
    else $error("grant key did not unlock");

  locked_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R8
    wr_done && map_write_locked && !hit_key
      |=> $stable(pin_function_select) && $stable(remap_repeat_allow))
    else $error("locked write changed state");

  answer_time_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    phase == pin_map_pkg::PH_IDLE && req |-> !pready ##1 !pready ##1 pready)
    else $error("answer not on third access cycle");

  answer_pulse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  answer_phase_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    phase != pin_map_pkg::PH_ANSWER |-> !pready && !pslverr)
    else $error("response outside answer cycle");

  err_response_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    phase == pin_map_pkg::PH_FETCH |=> pready && pslverr == !$past(mapped))
    else $error("error response wrong");

  write_rdata_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    phase == pin_map_pkg::PH_FETCH && pwrite |=> prdata == 32'h0000_0000)
    else $error("read data nonzero on write");

  unmapped_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    done && pwrite && !mapped
      |=> $stable(pin_function_select) && $stable(remap_repeat_allow)
        && $stable(map_write_locked))
    else $error("unmapped write changed state");

  permit_readback_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
    phase == pin_map_pkg::PH_FETCH && !pwrite && hit_ctrl
      |=> prdata[1] == $past(remap_repeat_allow))
    else $error("permit bit read back wrong");

  pin_readback_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R5
    phase == pin_map_pkg::PH_FETCH && !pwrite && hit_pin
      |=> prdata[SEL_BITS-1:0]
        == $past(pin_function_select[pin_idx*SEL_BITS +: SEL_BITS]))
    else $error("pin selector read back wrong");

  bad_key_lock_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R4
    key_wr && !key_good |=> map_write_locked)
    else $error("wrong key did not lock");

  single_session_a: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
    key_wr && key_good && session_used && !remap_repeat_allow
      |=> $stable(map_write_locked))
    else $error("second session opened without permit");

endmodule

// *** bench/tb_pin_function_map_regs.sv ***
`timescale 1ns/1ps

module tb_pin_function_map_regs;
  logic        core_clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [63:0] pin_function_select;
  logic        map_write_locked;
  logic        remap_repeat_allow;
  int          mismatches;
  int          samples_checked;
  int          cycles;

  pin_function_map_regs #(.PINS(8), .SEL_BITS(8)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_function_select(pin_function_select),
    .map_write_locked(map_write_locked), .remap_repeat_allow(remap_repeat_allow));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready, samples data at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic t_reset_state();
    rd(12'h004, 32'h0000_0001);
    rd(12'h000, 32'h0000_96a5);
    for (int i = 0; i < 8; i++) rd(12'h020 + 12'(4 * i), 32'h0);
    wr(12'h02c, 32'h0000_0033);
    wr(12'h004, 32'hffff_ffff);
    rd(12'h02c, 32'h0);
    rd(12'h004, 32'h0000_0001);
  endtask

  task automatic t_first_session();
    logic [63:0] exp_sel;
    wr(12'h000, 32'h0000_2d52);
    rd(12'h004, 32'h0);
    wr(12'h004, 32'hffff_ffff);
    rd(12'h004, 32'h0000_0002);
    for (int i = 0; i < 8; i++) begin
      wr(12'h020 + 12'(4 * i), 32'hffff_ff00 | 32'(8'h81 + 8'(i * 17)));
      exp_sel[i*8+:8] = 8'h81 + 8'(i * 17);
    end
    for (int i = 0; i < 8; i++) rd(12'h020 + 12'(4 * i), 32'(exp_sel[i*8+:8]));
    #1 chk(pin_function_select, exp_sel);
  endtask

  task automatic t_sessions();
    wr(12'h000, 32'h0000_1234);
    rd(12'h004, 32'h0000_0003);
    wr(12'h020, 32'h0000_0055);
    rd(12'h020, 32'h0000_0081);
    wr(12'h000, 32'h0000_2d52);
    rd(12'h004, 32'h0000_0002);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h0000_0000);
    wr(12'h000, 32'h0000_2d52);
    rd(12'h004, 32'h0000_0001);
    #1 chk({map_write_locked, remap_repeat_allow}, 64'h2);
  endtask

  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk({e, r}, {1'b1, 32'h0});
    apb(1'b1, 12'h022, 32'h0000_00ff, r, e);
    chk(e, 1'b1);
  endtask

  // Reset in mid-run clears selectors and lifts the one-session lock
  task automatic t_mid_reset();
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    #1 chk(pin_function_select, 64'h0);
    chk({map_write_locked, remap_repeat_allow}, 64'h2);
    wr(12'h000, 32'h0000_2d52);
    rd(12'h004, 32'h0);
  endtask

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset_state();
    t_first_session();
    t_sessions();
    t_unmapped();
    t_mid_reset();
    conclude();
  end
endmodule
